// ---- inc/ssv_defines.vh ----
// Constants for the supply supervisor output logic
`ifndef SSV_DEFINES_VH
`define SSV_DEFINES_VH
`define SSV_CLK_HZ          100000000
`define SSV_PURST_MS        200
`define SSV_PURST_CYC       ((`SSV_CLK_HZ / 1000) * `SSV_PURST_MS)
`define SSV_WDO_MS          150
`define SSV_WDO_CYC         ((`SSV_CLK_HZ / 1000) * `SSV_WDO_MS)
`define SSV_DEB_US          1000
`define SSV_DEB_CYC         ((`SSV_CLK_HZ / 1000000) * `SSV_DEB_US)
`define SSV_CNT_W           32
`endif

// ---- core/ssv_sync.v ----
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module ssv_sync
(
  // Clock and reset
  input  wire clk_sys,
  input  wire resetn,
  // Level
  input  wire d_in,
  output reg  q_out
);
  reg meta_r;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// ---- core/ssv_top.v ----
// Supply supervisor reset, fail, watchdog and switch-over outputs
`timescale 1ns/1ps
`include "ssv_defines.vh"

// Functional notes
// - Second fail output low while second monitor below its trip level.
// - Reset output asserts whenever main supply is below minimum sense level.
// - After main supply returns, reset held for full power-up reset period.
// - At power-up reset asserts and holds for the power-up reset period.
// - While reset is asserted, serial traffic ignored and transfers aborted.
// - Manual reset input is debounced; reset asserts while it is active.
// - After manual reset release, reset held for power-up reset period.
// - Watchdog output goes active when the watchdog timer expires.
// - Watchdog output stays active a fixed pulse, then releases itself.
// - Serial data pin is open-drain; device never drives it high.
// - Host supplies serial clock; device clocks data bits with it.
// - Switched output follows main above trip; below, hysteresis around backup.
// - Logic keeps running and keeps state from backup when main fails.
// - Second fail output follows its comparator with no stretching delay.
// - Main-low warning low below first trip, high at once above it.
// - Backup-active high when backup selected, low when main selected.
module ssv_top
#(
  parameter [`SSV_CNT_W-1:0] PURST_CYC = `SSV_PURST_CYC,
  parameter [`SSV_CNT_W-1:0] WDO_CYC   = `SSV_WDO_CYC,
  parameter [`SSV_CNT_W-1:0] DEB_CYC   = `SSV_DEB_CYC
)
(
  // Clock and power-on reset
  input  wire clk_sys,
  input  wire resetn,
  // Comparator results, high when supply above level
  input  wire main_above_trip,
  input  wire second_above_trip,
  input  wire main_above_batt_hi,
  input  wire main_above_batt_lo,
  // Manual reset and watchdog expiry
  input  wire manual_reset_n,
  input  wire watchdog_expire,
  // Serial bus pins
  input  wire scl_in,
  input  wire sda_in,
  output reg  sda_out,
  output reg  sda_oe,
  input  wire core_sda_drive_low,
  // Status to serial core
  output reg  bus_abort,
  output reg  bit_strobe,
  output reg  bit_value,
  // Supervisor outputs
  output reg  reset_out_n,
  output reg  reset_oe,
  output reg  second_supply_fail_n,
  output reg  main_low_n,
  output reg  watchdog_out_n,
  output reg  watchdog_oe,
  output reg  backup_active
);
  localparam ST_HOLD = 3'b001;
  localparam ST_STR  = 3'b010;
  localparam ST_RUN  = 3'b100;

  wire main_ok_s;
  wire second_ok_s;
  wire batt_hi_s;
  wire batt_lo_s;
  wire mr_s;
  wire wd_s;
  wire scl_s;
  wire [5:0] sync_in;
  wire [5:0] sync_out;

  reg  [2:0]            st_r;
  reg  [2:0]            st_nxt;
  reg  [`SSV_CNT_W-1:0] rst_cnt_r;
  reg  [`SSV_CNT_W-1:0] deb_cnt_r;
  reg                   mr_deb_r;
  reg  [`SSV_CNT_W-1:0] wd_cnt_r;
  reg                   wd_prev_r;
  reg                   scl_prev_r;
  reg                   sel_batt_r;

  assign sync_in = {scl_in, watchdog_expire, manual_reset_n, main_above_batt_lo, main_above_batt_hi, second_above_trip};
  assign second_ok_s = sync_out[0];
  assign batt_hi_s   = sync_out[1];
  assign batt_lo_s   = sync_out[2];
  assign mr_s        = sync_out[3];
  assign wd_s        = sync_out[4];
  assign scl_s       = sync_out[5];

  // Synchronise all asynchronous comparator and pin levels except sda_in, which is registered once
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_sync
      ssv_sync u_sync
      (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .d_in     (sync_in[gi]),
        .q_out    (sync_out[gi])
      );
    end
  endgenerate

  ssv_sync u_sync_main
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .d_in     (main_above_trip),
    .q_out    (main_ok_s)
  );

  // Debounce: input must stay steady for the whole window
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      deb_cnt_r <= {`SSV_CNT_W{1'b0}};
      mr_deb_r  <= 1'b1;
    end
    else if (mr_s == mr_deb_r)
      deb_cnt_r <= {`SSV_CNT_W{1'b0}};
    else if (deb_cnt_r >= DEB_CYC - 1'b1)
    begin
      deb_cnt_r <= {`SSV_CNT_W{1'b0}};
      mr_deb_r  <= mr_s;
    end
    else
      deb_cnt_r <= deb_cnt_r + 1'b1;
  end

  // Reset sequencer; power-on reset enters HOLD, so follows
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      ST_HOLD:
        if (main_ok_s && mr_deb_r)
          st_nxt = ST_STR;
      ST_STR:
        if (!main_ok_s || !mr_deb_r)
          st_nxt = ST_HOLD;
        else if (rst_cnt_r >= PURST_CYC - 1'b1)
          st_nxt = ST_RUN;
      ST_RUN:
        if (!main_ok_s || !mr_deb_r)
          st_nxt = ST_HOLD;
      default:
        st_nxt = ST_HOLD;
    endcase
  end

  // Stretch counter from the system timebase
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r      <= ST_HOLD;
      rst_cnt_r <= {`SSV_CNT_W{1'b0}};
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == ST_STR && st_nxt == ST_STR)
        rst_cnt_r <= rst_cnt_r + 1'b1;
      else
        rst_cnt_r <= {`SSV_CNT_W{1'b0}};
    end
  end

  // Watchdog pulse; a new expiry during a pulse is absorbed
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wd_prev_r      <= 1'b0;
      wd_cnt_r       <= {`SSV_CNT_W{1'b0}};
      watchdog_out_n <= 1'b1;
      watchdog_oe    <= 1'b0;
    end
    else
    begin
      wd_prev_r <= wd_s;
      if (watchdog_out_n && wd_s && !wd_prev_r)
      begin
        watchdog_out_n <= 1'b0;
        watchdog_oe    <= 1'b1;
        wd_cnt_r       <= {`SSV_CNT_W{1'b0}};
      end
      else if (!watchdog_out_n)
      begin
        if (wd_cnt_r >= WDO_CYC - 1'b1)
        begin
          watchdog_out_n <= 1'b1;
          watchdog_oe    <= 1'b0;
        end
        wd_cnt_r <= wd_cnt_r + 1'b1;
      end
    end
  end

  // Supply outputs and switch-over; state kept while on backup
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_out_n          <= 1'b0;
      reset_oe             <= 1'b1;
      second_supply_fail_n <= 1'b0;
      main_low_n           <= 1'b0;
      sel_batt_r           <= 1'b0;
      backup_active        <= 1'b0;
    end
    else
    begin
      reset_out_n          <= (st_nxt == ST_RUN);
      reset_oe             <= (st_nxt != ST_RUN);
      second_supply_fail_n <= second_ok_s;
      main_low_n           <= main_ok_s;
      if (main_ok_s)
        sel_batt_r <= 1'b0;
      else if (batt_hi_s)
        sel_batt_r <= 1'b0;
      else if (!batt_lo_s)
        sel_batt_r <= 1'b1;
      backup_active <= sel_batt_r;
    end
  end

  // Serial pin gating; bits taken on host clock rising edge
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_prev_r <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      bus_abort  <= 1'b1;
      bit_strobe <= 1'b0;
      bit_value  <= 1'b0;
    end
    else
    begin
      scl_prev_r <= scl_s;
      // Gated from the same next state as the reset pin, so no cycle slips through
      bus_abort  <= (st_nxt != ST_RUN);
      bit_strobe <= (st_nxt == ST_RUN) && scl_s && !scl_prev_r;
      bit_value  <= sda_in;
      sda_out    <= 1'b0;
      sda_oe     <= (st_nxt == ST_RUN) && core_sda_drive_low;
    end
  end
endmodule

// ---- verification/ssv_properties.sv ----
// Checker on the supervisor top ports
`timescale 1ns/1ps
module ssv_properties #(parameter int PURST_CYC = 20, DEB_CYC = 4, WDO_CYC = 15)
(
  // Top ports
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic main_above_trip,
  input wire logic second_above_trip,
  input wire logic main_above_batt_lo,
  input wire logic manual_reset_n,
  input wire logic sda_out,
  input wire logic bus_abort,
  input wire logic bit_strobe,
  input wire logic reset_out_n,
  input wire logic reset_oe,
  input wire logic second_supply_fail_n,
  input wire logic main_low_n,
  input wire logic watchdog_out_n,
  input wire logic backup_active
);
  int ok_r;
  int wd_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence main_held;
    main_above_trip [*6];
  endsequence
  // Good-supply run and pulse-low run lengths
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      ok_r <= 0;
      wd_r <= 0;
    end
    else
    begin
      ok_r <= (main_above_trip && manual_reset_n) ? ok_r + 1 : 0;
      wd_r <= watchdog_out_n ? 0 : wd_r + 1;
    end
  a_fail_follow: assert property ($changed(second_above_trip) |->
    ##3 second_supply_fail_n == $past(second_above_trip, 3)) else $error("fail output wrong");
  a_low_warn: assert property ($changed(main_above_trip) |->
    ##3 main_low_n == $past(main_above_trip, 3)) else $error("low warning wrong");
  a_reset_drop: assert property ($fell(main_above_trip) |-> ##[1:4] !reset_out_n)
    else $error("reset not asserted");
  a_reset_oe: assert property (reset_oe == !reset_out_n) else $error("reset enable wrong");
  a_stretch_len: assert property ($rose(reset_out_n) |->
    ok_r >= PURST_CYC && ok_r <= PURST_CYC + DEB_CYC + 8) else $error("stretch length wrong");
  a_abort_gate: assert property (!reset_out_n |->
    bus_abort && !bit_strobe) else $error("bus not gated");
  a_wdo_len: assert property ($rose(watchdog_out_n) |-> wd_r == WDO_CYC)
    else $error("pulse length wrong");
  a_backup_sel: assert property ($fell(main_above_batt_lo) && !main_above_trip |->
    ##4 backup_active) else $error("backup not selected");
  a_main_sel: assert property (main_held |-> !backup_active) else $error("main not selected");
  a_sda_od: assert property (!sda_out) else $error("data driven high");
endmodule
bind ssv_top ssv_properties #(.PURST_CYC(PURST_CYC), .DEB_CYC(DEB_CYC), .WDO_CYC(WDO_CYC)) chk_u (.*);

// ---- verification/ssv_host.sv ----
// Host model: framed serial clock and pulled-up data line
`timescale 1ns/1ps
module ssv_host
(
  // Clock and frame control
  input  wire logic clk_sys,
  input  wire logic run,
  // Serial lines
  input  wire logic dev_pull_low,
  output wire logic scl,
  output wire logic sda
);
  logic [1:0] div_r = 2'h0;
  logic       host_low_r = 1'b0;
  // Clock stands high between frames
  always @(posedge clk_sys)
  begin
    div_r <= run ? div_r + 2'h1 : 2'h0;
    if (!run)
      host_low_r <= 1'b0;
    else if (div_r == 2'h3)
      host_low_r <= ~host_low_r;
  end
  assign scl = ~run | div_r[1];
  // Pull-up wins unless someone pulls low
  assign sda = (dev_pull_low | host_low_r) ? 1'b0 : 1'b1;
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the supervisor outputs
`timescale 1ns/1ps
module tb;
  localparam int P = 20, D = 4, W = 15;
  logic clk_sys = 0, resetn = 0, main_above_trip = 1, second_above_trip = 1, main_above_batt_hi = 1;
  logic main_above_batt_lo = 1, manual_reset_n = 1, watchdog_expire = 0, core_sda_drive_low = 0, run = 0;
  wire scl_in, sda_in, sda_out, sda_oe, bus_abort, bit_strobe, bit_value, reset_out_n, reset_oe;
  wire second_supply_fail_n, main_low_n, watchdog_out_n, watchdog_oe, backup_active;
  int errors = 0, num_checks = 0, n, m, w, i;
  // Rows: main, second, hi, lo, then main_low_n, fail_n, backup
  logic [6:0] rows [8] = '{7'h7E, 7'h5C, 7'h3A, 7'h23, 7'h2B, 7'h3A, 7'h2A, 7'h66};
  ssv_top #(.PURST_CYC(P), .WDO_CYC(W), .DEB_CYC(D)) dut_u (.*);
  ssv_host host_u (.clk_sys, .run, .dev_pull_low(sda_oe), .scl(scl_in), .sda(sda_in));
  always #5 clk_sys = ~clk_sys;
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (e !== g)
    begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", s, e, g);
    end
  endtask
  task automatic mon(int k);
    repeat (k)
    begin
      @(negedge clk_sys);
      m += bit_strobe;
      w += !watchdog_out_n;
    end
  endtask
  task automatic rel_wait;
    n = 0;
    while (reset_out_n !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("reset_release", 1, n >= P && n <= P + D + 8);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    mon(20);
    chk("reset_out_n", 0, reset_out_n);
    resetn = 1;
    rel_wait;
    for (i = 0; i < 8; i++)
    begin
      {main_above_trip, second_above_trip, main_above_batt_hi, main_above_batt_lo} = rows[i][6:3];
      mon(6);
      chk("main_low_n", rows[i][2], main_low_n);
      chk("second_supply_fail_n", rows[i][1], second_supply_fail_n);
      chk("backup_active", rows[i][0], backup_active);
    end
    mon(40);
    main_above_trip = 0;
    mon(5);
    chk("reset_out_n", 0, reset_out_n);
    main_above_trip = 1;
    rel_wait;
    manual_reset_n = 0;
    mon(2);
    manual_reset_n = 1;
    mon(8);
    chk("reset_out_n", 1, reset_out_n);
    {run, core_sda_drive_low} = 2'b11;
    manual_reset_n = 0;
    mon(8);
    m = 0;
    mon(12);
    chk("reset_out_n", 0, reset_out_n);
    chk("strobes", 0, m);
    chk("sda_oe", 0, sda_oe);
    chk("bus_abort", 1, bus_abort);
    manual_reset_n = 1;
    rel_wait;
    m = 0;
    mon(40);
    chk("strobes", 1, m >= 9 && m <= 10);
    chk("sda_in", 0, sda_in);
    chk("bit_value", 0, bit_value);
    {run, core_sda_drive_low, w} = 0;
    watchdog_expire = 1;
    mon(8);
    chk("watchdog_oe", 1, watchdog_oe);
    watchdog_expire = 0;
    mon(2);
    // Second expiry lands inside the pulse
    watchdog_expire = 1;
    mon(40);
    chk("watchdog_low", W, w);
    watchdog_expire = 0;
    chk("watchdog_oe", 0, watchdog_oe);
    chk("sda_in", 1, sda_in);
    chk("bit_value", 1, bit_value);
    // Power-on reset again in mid-run
    resetn = 0;
    mon(3);
    chk("reset_out_n", 0, reset_out_n);
    chk("bus_abort", 1, bus_abort);
    resetn = 1;
    rel_wait;
    stop_test;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    stop_test;
  end
endmodule
